// [rtl/cdsk_controller.sv]
// Host-side controller that programs a clock manager's deskew settings.
// Assumes the clock manager takes its settings as static levels on pins and
// reports deskew lock as a level; all inputs are synchronous to clk_in.
`default_nettype none
module cdsk_controller #(
  parameter int NUM_OUT = cdsk_pkg::NUM_OUTPUTS
) (
  input  wire logic                    clk_in,
  input  wire logic                    reset_n_in,
  // User side
  input  wire logic                    start_in,
  input  wire cdsk_pkg::cdsk_order_type order_in,
  input  wire logic                    stop_in,
  output logic                         busy_out,
  output logic                         active_out,
  output logic                         error_out,
  // Device side
  output logic [2*NUM_OUT-1:0]         phase_ctrl_select_out,
  output cdsk_pkg::cdsk_delay_type     deskew_one_delay_out,
  output cdsk_pkg::cdsk_delay_type     deskew_two_delay_out,
  output cdsk_pkg::cdsk_comp_type      compensation_out,
  output logic                         feedback_counter_route_out,
  output logic                         zero_hold_setting_out,
  output logic                         deskew_reference_from_main_out,
  output logic                         manager_reset_out,
  input  wire logic                    deskew_locked_in
);
  import cdsk_pkg::*;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE   = 3'h0,
    ST_CHECK  = 3'h1,
    ST_LOAD   = 3'h2,
    ST_SETTLE = 3'h3,
    ST_RUN    = 3'h4
  } cdsk_state_type;

  cdsk_state_type state_q, state_d;
  cdsk_order_type order_q, order_d;
  logic [4:0]     settle_q, settle_d;
  logic           error_q, error_d;
  logic           load_sel;
  logic           order_ok;
  logic [1:0]     chosen_sel;

  // The fed-back output must be placed under a deskew circuit.
  assign chosen_sel = order_q.use_circuit_two ? PHASE_CTRL_DESKEW2
                                              : PHASE_CTRL_DESKEW1;

  // Illegal orders are refused before anything reaches the device, since a
  // half-programmed manager could lose lock with no clean recovery.
  always_comb begin
    order_ok = 1'b1;
    if (32'(order_q.deskew_output) >= NUM_OUT) begin
      order_ok = 1'b0;
    end
    if (order_q.manager == MGR_MIXED_MODE && !order_q.feedback_internal) begin
      order_ok = 1'b0;
    end
    if (order_q.manager != MGR_MIXED_MODE && order_q.manager != MGR_DIGITAL &&
        order_q.manager != MGR_HIGH_SPEED) begin
      order_ok = 1'b0;
    end
    if (order_q.zero_delay_buffer && order_q.feedback_internal) begin
      order_ok = 1'b0;
    end
    if (order_q.delay.taps > TAP_MAX) begin
      order_ok = 1'b0;
    end
  end

  always_comb begin
    state_d  = state_q;
    order_d  = order_q;
    settle_d = settle_q;
    error_d  = error_q;
    load_sel = 1'b0;
    unique case (state_q)
      ST_IDLE: begin
        if (start_in) begin
          order_d = order_in;
          error_d = 1'b0;
          state_d = ST_CHECK;
        end
      end
      ST_CHECK: begin
        if (order_ok) begin
          state_d = ST_LOAD;
        end else begin
          error_d = 1'b1;
          state_d = ST_IDLE;
        end
      end
      ST_LOAD: begin
        load_sel = 1'b1;
        settle_d = SETTLE_CNT;
        state_d  = ST_SETTLE;
      end
      ST_SETTLE: begin
        if (settle_q == 5'h00) begin
          state_d = ST_RUN;
        end else begin
          settle_d = settle_q - 5'h01;
        end
      end
      ST_RUN: begin
        // The device keeps stepping on its own; the host only holds settings.
        if (stop_in) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      state_q  <= ST_IDLE;
      order_q  <= '0;
      settle_q <= 5'h00;
      error_q  <= 1'b0;
    end else begin
      state_q  <= state_d;
      order_q  <= order_d;
      settle_q <= settle_d;
      error_q  <= error_d;
    end
  end

  // ----------------------------------------------------------------
  // Per-output interpolator selects
  // ----------------------------------------------------------------
  for (genvar i = 0; i < NUM_OUT; i++) begin : g_slot
    logic [1:0] sel_i;
    always_comb begin
      sel_i = (32'(order_q.deskew_output) == i) ? chosen_sel : PHASE_CTRL_NONE;
    end
    cdsk_phase_ctrl_slot u_slot (
      .clk_in     (clk_in),
      .reset_n_in (reset_n_in),
      .load_in    (load_sel),
      .sel_in     (sel_i),
      .sel_out    (phase_ctrl_select_out[2*i +: 2])
    );
  end

  // ----------------------------------------------------------------
  // Device settings, registered
  // ----------------------------------------------------------------
  cdsk_delay_type d1_q, d1_d, d2_q, d2_d;
  cdsk_comp_type  comp_q, comp_d;
  logic           fb_route_q, fb_route_d;
  logic           zero_hold_setting_q, zero_hold_setting_d;
  logic           ref_main_q, ref_main_d;
  logic           mrst_q, mrst_d;

  always_comb begin
    d1_d       = d1_q;
    d2_d       = d2_q;
    comp_d     = comp_q;
    fb_route_d = fb_route_q;
    zero_hold_setting_d    = zero_hold_setting_q;
    ref_main_d = ref_main_q;
    mrst_d     = (state_d == ST_LOAD) || (state_q == ST_LOAD);
    if (load_sel) begin
      d1_d = order_q.use_circuit_two ? '0 : order_q.delay;
      d2_d = order_q.use_circuit_two ? order_q.delay : '0;
      // Internal feedback never carries the multiply counter off chip.
      comp_d = order_q.feedback_internal ? COMP_INTERNAL : COMP_EXTERNAL;
      // Normal feedback is always kept connected alongside deskew.
      fb_route_d = (comp_d != COMP_AUTO);
      zero_hold_setting_d    = (order_q.manager == MGR_DIGITAL) && order_q.zero_delay_buffer;
      // Every manager type, digital or not, takes the main clock as reference.
      ref_main_d = 1'b1;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      d1_q       <= '0;
      d2_q       <= '0;
      comp_q     <= COMP_AUTO;
      fb_route_q <= 1'b0;
      zero_hold_setting_q    <= 1'b0;
      ref_main_q <= 1'b0;
      mrst_q     <= 1'b1;
    end else begin
      d1_q       <= d1_d;
      d2_q       <= d2_d;
      comp_q     <= comp_d;
      fb_route_q <= fb_route_d;
      zero_hold_setting_q    <= zero_hold_setting_d;
      ref_main_q <= ref_main_d;
      mrst_q     <= mrst_d;
    end
  end

  assign deskew_one_delay_out           = d1_q;
  assign deskew_two_delay_out           = d2_q;
  assign compensation_out               = comp_q;
  assign feedback_counter_route_out     = fb_route_q;
  assign zero_hold_setting_out          = zero_hold_setting_q;
  assign deskew_reference_from_main_out = ref_main_q;
  assign manager_reset_out              = mrst_q;
  assign busy_out   = (state_q != ST_IDLE) && (state_q != ST_RUN);
  assign active_out = (state_q == ST_RUN) && deskew_locked_in;
  assign error_out  = error_q;
endmodule : cdsk_controller
`default_nettype wire

// [rtl/cdsk_pkg.sv]
// Package for the clock output deskew controller (host side).
// Assumes a single 125 MHz clock domain and a synchronous active-low reset.
`default_nettype none
package cdsk_pkg;
  // ----------------------------------------------------------------
  // Interpolator control encoding
  // ----------------------------------------------------------------
  localparam logic [1:0] PHASE_CTRL_NONE    = 2'h0;
  localparam logic [1:0] PHASE_CTRL_DESKEW1 = 2'h1;
  localparam logic [1:0] PHASE_CTRL_FINE    = 2'h2;
  localparam logic [1:0] PHASE_CTRL_DESKEW2 = 2'h3;
  // ----------------------------------------------------------------
  // Sizes and timing
  // ----------------------------------------------------------------
  localparam int          NUM_OUTPUTS     = 7;
  localparam int          PHASE_COUNT     = 32;
  localparam int          PHASE_W         = 5;
  localparam int          TAP_W           = 6;
  localparam logic [5:0]  TAP_MAX         = 6'h3F;
  localparam int          TAP_STEP_PS     = 40;
  localparam int          CLK_PERIOD_PS   = 8000;
  localparam int          SETTLE_TIME_NS  = 100;
  localparam int          SETTLE_CYCLES   = (SETTLE_TIME_NS * 1000 + CLK_PERIOD_PS - 1)
                                            / CLK_PERIOD_PS;
  localparam logic [4:0]  SETTLE_CNT      = 5'(SETTLE_CYCLES);
  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    COMP_AUTO     = 2'h0,
    COMP_EXTERNAL = 2'h1,
    COMP_INTERNAL = 2'h2,
    COMP_BUF_IN   = 2'h3
  } cdsk_comp_type;

  typedef enum logic [1:0] {
    MGR_MIXED_MODE = 2'h0,
    MGR_DIGITAL    = 2'h1,
    MGR_HIGH_SPEED = 2'h2
  } cdsk_mgr_type;

  // One deskew circuit's delay setting as driven to the device.
  typedef struct packed {
    logic             enable;
    logic             on_reference;
    logic [TAP_W-1:0] taps;
  } cdsk_delay_type;

  // User order for one configuration.
  typedef struct packed {
    cdsk_mgr_type   manager;
    logic [2:0]     deskew_output;
    logic           use_circuit_two;
    logic           feedback_internal;
    logic           zero_delay_buffer;
    cdsk_delay_type delay;
  } cdsk_order_type;
endpackage : cdsk_pkg
`default_nettype wire

// [rtl/cdsk_phase_ctrl_slot.sv]
// One output's interpolator control select, held until a new configuration.
// Assumes loads come from the controller's configuration sequence only.
`default_nettype none
module cdsk_phase_ctrl_slot (
  input  wire logic       clk_in,
  input  wire logic       reset_n_in,
  input  wire logic       load_in,
  input  wire logic [1:0] sel_in,
  output logic      [1:0] sel_out
);
  import cdsk_pkg::*;
  logic [1:0] sel_q;
  logic [1:0] sel_d;

  always_comb begin
    sel_d = load_in ? sel_in : sel_q;
  end

  always_ff @(posedge clk_in) begin
    if (!reset_n_in) begin
      sel_q <= PHASE_CTRL_NONE;
    end else begin
      sel_q <= sel_d;
    end
  end

  assign sel_out = sel_q;
endmodule : cdsk_phase_ctrl_slot
`default_nettype wire

// [tb/cdsk_controller_asserts.sv]
// Port checks for the deskew controller.
// Assumes it is bound to cdsk_controller; one clock, sync reset.
`default_nettype none
module cdsk_controller_chk
  import cdsk_pkg::*;
#(parameter int NUM_OUT = 7) (
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic busy_out,
  input wire logic active_out,
  input wire logic error_out,
  input wire logic [2*NUM_OUT-1:0] phase_ctrl_select_out,
  input wire cdsk_pkg::cdsk_delay_type deskew_one_delay_out,
  input wire cdsk_pkg::cdsk_delay_type deskew_two_delay_out,
  input wire cdsk_pkg::cdsk_comp_type compensation_out,
  input wire logic feedback_counter_route_out,
  input wire logic deskew_reference_from_main_out,
  input wire logic deskew_locked_in
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!reset_n_in);
  property p_reset; disable iff (1'b0) !reset_n_in |=> compensation_out == COMP_AUTO
    && phase_ctrl_select_out == '0 && !busy_out;
  endproperty
  a_reset: assert property (p_reset) else $error("reset state wrong");
  property p_route_auto; compensation_out == COMP_AUTO |-> !feedback_counter_route_out;
  endproperty
  a_route_auto: assert property (p_route_auto) else $error("route on under auto");
  property p_route_fb; compensation_out != COMP_AUTO |-> feedback_counter_route_out;
  endproperty
  a_route_fb: assert property (p_route_fb) else $error("feedback not routed");
  property p_one_circ; !(deskew_one_delay_out.enable && deskew_two_delay_out.enable);
  endproperty
  a_one_circ: assert property (p_one_circ) else $error("both delays on");
  property p_active; active_out |-> deskew_locked_in && !busy_out && !error_out;
  endproperty
  a_active: assert property (p_active) else $error("active without lock");
  property p_settle; $rose(busy_out) |-> ##[1:24] !busy_out;
  endproperty
  a_settle: assert property (p_settle) else $error("busy too long");
  property p_ref_main; $fell(busy_out) && !error_out |-> deskew_reference_from_main_out
    && compensation_out != COMP_AUTO;
  endproperty
  a_ref_main: assert property (p_ref_main) else $error("load settings wrong");
  property p_hold; !busy_out |=> $stable(deskew_one_delay_out)
    && $stable(phase_ctrl_select_out);
  endproperty
  a_hold: assert property (p_hold) else $error("settings moved while idle");
endmodule : cdsk_controller_chk
bind cdsk_controller cdsk_controller_chk #(.NUM_OUT(NUM_OUT)) u_chk (.clk_in, .reset_n_in,
  .busy_out, .active_out, .error_out, .phase_ctrl_select_out, .deskew_one_delay_out,
  .deskew_two_delay_out, .compensation_out, .feedback_counter_route_out,
  .deskew_reference_from_main_out, .deskew_locked_in);
`default_nettype wire

// [tb/cdsk_device_model.sv]
// Behavioural clock manager: one interpolator steered to a reference phase.
// Assumes static settings from the controller on the bench's clock.
`default_nettype none
module cdsk_device_model
  import cdsk_pkg::*;
#(parameter int NUM_OUT = 7, parameter logic [4:0] REF_PHASE = 5'h13) (
  input wire logic clk_in,
  input wire logic [2*NUM_OUT-1:0] phase_ctrl_select_in,
  input wire cdsk_pkg::cdsk_delay_type delay_one_in,
  input wire cdsk_pkg::cdsk_delay_type delay_two_in,
  input wire cdsk_pkg::cdsk_comp_type compensation_in,
  input wire logic manager_reset_in,
  output logic locked_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [4:0] phase_q;
  logic [4:0] target;
  logic engaged;
  always_comb begin
    engaged = 1'b0;
    for (int i = 0; i < NUM_OUT; i++) begin
      if (phase_ctrl_select_in[2*i+:2] inside {PHASE_CTRL_DESKEW1, PHASE_CTRL_DESKEW2}) begin
        engaged = compensation_in != COMP_AUTO;
      end
    end
    target = REF_PHASE;
    if (delay_one_in.enable) target = REF_PHASE + delay_one_in.taps[4:0];
    if (delay_two_in.enable) target = REF_PHASE + delay_two_in.taps[4:0];
  end
  // The shorter way round is taken, so lock never needs more than 16 steps.
  always_ff @(posedge clk_in) begin
    if (manager_reset_in) phase_q <= 5'h00;
    else if (engaged && phase_q != target) phase_q <= (5'(target - phase_q) < 5'h10) ?
      phase_q + 5'h01 : phase_q - 5'h01;
  end
  assign locked_out = engaged && !manager_reset_in && phase_q == target;
endmodule : cdsk_device_model
`default_nettype wire

// [tb/cdsk_controller_test.sv]
// Self-checking bench for the deskew controller and a device model.
// Assumes the design package and the bound port checker.
`default_nettype none
module cdsk_controller_test;
  timeunit 1ns;
  timeprecision 100ps;
  import cdsk_pkg::*;
  logic clk_in = 1'b0, reset_n_in = 1'b0, start_in = 1'b0, stop_in = 1'b0;
  logic busy_out, active_out, error_out, route, zero_hold_setting, ref_main, mgr_rst, locked;
  logic [13:0] sel;
  cdsk_order_type order_in = '0;
  cdsk_delay_type d1, d2;
  cdsk_comp_type comp;
  int err_count = 0;
  int tests_run = 0;
  always #4 clk_in = ~clk_in;
  cdsk_controller u_dut (.clk_in, .reset_n_in, .start_in, .order_in, .stop_in, .busy_out,
    .active_out, .error_out, .phase_ctrl_select_out(sel), .deskew_one_delay_out(d1),
    .deskew_two_delay_out(d2), .compensation_out(comp), .feedback_counter_route_out(route),
    .zero_hold_setting_out(zero_hold_setting), .deskew_reference_from_main_out(ref_main),
    .manager_reset_out(mgr_rst), .deskew_locked_in(locked));
  cdsk_device_model u_dev (.clk_in, .phase_ctrl_select_in(sel), .delay_one_in(d1),
    .delay_two_in(d2), .compensation_in(comp), .manager_reset_in(mgr_rst), .locked_out(locked));
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic results();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : results
  function automatic logic ok(input cdsk_order_type o);
    return o.deskew_output < 3'(NUM_OUTPUTS) && o.manager != 2'h3 && !(o.zero_delay_buffer
      && o.feedback_internal) && (o.manager != MGR_MIXED_MODE || o.feedback_internal);
  endfunction : ok
  task automatic run(input cdsk_order_type o);
    logic [13:0] e;
    int n;
    e = '0;
    e[2*o.deskew_output +: 2] = o.use_circuit_two ? PHASE_CTRL_DESKEW2 : PHASE_CTRL_DESKEW1;
    order_in = o;
    start_in = 1'b1;
    @(posedge clk_in);
    #1 start_in = 1'b0;
    n = 0;
    while (busy_out !== 1'b0 && n < 40) begin
      @(posedge clk_in);
      #1 n++;
    end
    chk("error", 16'(!ok(o)), 16'(error_out));
    if (ok(o)) begin
      chk("settle", 16'(SETTLE_CYCLES + 3), 16'(n));
      while (active_out !== 1'b1 && n < 120) begin
        @(posedge clk_in);
        #1 n++;
      end
      chk("active", 16'h1, 16'(active_out));
      chk("select", 16'(e), 16'(sel));
      chk("delay1", o.use_circuit_two ? 16'h0 : {8'h0, o.delay}, {8'h0, d1});
      chk("delay2", o.use_circuit_two ? {8'h0, o.delay} : 16'h0, {8'h0, d2});
      chk("comp", o.feedback_internal ? 16'(COMP_INTERNAL) : 16'(COMP_EXTERNAL), 16'(comp));
      chk("route", 16'h1, 16'(route));
      chk("zero_hold_setting", 16'(o.manager == MGR_DIGITAL && o.zero_delay_buffer), 16'(zero_hold_setting));
      chk("refmain", 16'h1, 16'(ref_main));
      chk("mgr_rst", 16'h0, 16'(mgr_rst));
    end
    stop_in = 1'b1;
    @(posedge clk_in);
    #1 stop_in = 1'b0;
    @(posedge clk_in);
    #1;
    chk("stopped", 16'h0, 16'(active_out));
  endtask : run
  initial begin
    cdsk_order_type o;
    void'($urandom(29));
    repeat (16) @(posedge clk_in);
    #1;
    chk("reset_sel", 16'h0, 16'(sel));
    chk("reset_mgr", 16'h1, 16'(mgr_rst));
    reset_n_in = 1'b1;
    for (int k = 0; k < 24; k++) begin
      o = cdsk_order_type'(16'($urandom));
      if (k % 3 != 2) begin
        o.manager = cdsk_mgr_type'(k % 3);
        o.deskew_output = 3'(k % 7);
        o.feedback_internal = !o.zero_delay_buffer;
      end
      if (k == 0)
        o.delay = '{1'b1, 1'b1, TAP_MAX};
      run(o);
    end
    results();
  end
  // Orders take under 80 cycles each, so this span is far beyond a healthy run.
  initial begin
    #200000;
    err_count++;
    results();
  end
endmodule : cdsk_controller_test
`default_nettype wire
